// *** hdl/snwt_top.sv ***
// The APB interface to the registers and the placing of the registers were decided locally.
`timescale 1ns/1ps
module snwt_top
  import snwt_pkg::*;
(
  // Clock and reset
  input wire logic clk,
  input wire logic srst,
  // APB slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // Reception events from the receive engine
  input wire logic rx_done,
  input wire logic [4:0] rx_sid,
  // Interrupt
  output logic irq
);
  snwt_evt_if evt();

  logic [31:0] ctrl_q;
  logic [NODES-1:0] mode_q;
  logic [1:0] stat_q;
  logic [1:0] mask_q;
  logic [CNT_W-1:0] wt_q;
  logic [31:0] prdata_q;
  logic soft_rst;
  logic run;
  logic tick;
  logic [2:0] res_sel;
  logic [3:0] carry_sel;
  logic [4:0] max_id;
  logic [NODES-1:0] monitor;
  logic all_set;
  logic carry;
  logic wr;
  logic rd;
  logic hit;
  logic cmd_wr;
  logic host_clr;
  logic wt_clr;
  logic err_set;
  logic [31:0] rdata;

  // Register access
  assign wr = psel && penable && pwrite;
  assign rd = psel && penable && !pwrite;
  assign hit = (paddr == ADDR_CTRL) || (paddr == ADDR_MODE) ||
               (paddr == ADDR_FLAGS) || (paddr == ADDR_CMD) ||
               (paddr == ADDR_STAT) || (paddr == ADDR_MASK);
  assign pready = 1'b1;
  assign pslverr = psel && penable && !hit;
  assign cmd_wr = wr && (paddr == ADDR_CMD);

  assign soft_rst = ctrl_q[CTRL_RST];
  assign res_sel = ctrl_q[CTRL_RES_LSB +: 3];
  assign carry_sel = ctrl_q[CTRL_CARRY_LSB +: 4];
  assign max_id = ctrl_q[CTRL_HIGHEST_NODE_ID_LSB +: 5];
  // Illegal carry code 0 keeps the timer idle
  assign run = !soft_rst && (carry_sel != 4'h0);

  genvar i;
  for (i = 0; i < NODES; i++) begin : g_mon
    assign monitor[i] = mode_q[i] && (ID_W'(i + 1) <= max_id);
  end

  assign all_set = &(evt.flags | ~monitor);
  // Carry-out at rising of counter bit n
  assign carry = tick && (wt_q[carry_sel] == 1'b0) &&
                 (&wt_q[CNT_W-2:0] | (wt_q & ((CNT_W'(1) << carry_sel)
                 - CNT_W'(1))) == ((CNT_W'(1) << carry_sel) - CNT_W'(1)));
  assign host_clr = cmd_wr && pwdata[CMD_FLAG_CLR];
  assign wt_clr = cmd_wr && pwdata[CMD_WT_CLR];
  assign err_set = carry && !all_set;

  assign evt.rx_valid = rx_done && !soft_rst;
  assign evt.rx_sid = rx_sid;
  assign evt.monitor = monitor;
  // Flags also clear when a clean period ends
  assign evt.flag_clr = host_clr || (carry && all_set);

  snwt_prescale u_pre (
    .clk(clk),
    .srst(srst),
    .run(run),
    .res_sel(res_sel),
    .tick(tick)
  );

  snwt_flags u_flags (
    .clk(clk),
    .srst(srst || soft_rst),
    .evt(evt)
  );

  // Watch counter wraps by itself so periods abut
  always_ff @(posedge clk) begin
    if (srst || !run) begin
      wt_q <= '0;
    end else if (carry) begin
      wt_q <= '0;
    end else if (tick) begin
      wt_q <= wt_q + 1'b1;
    end
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      ctrl_q <= CTRL_RESET;
      mode_q <= '0;
      mask_q <= '0;
    end else if (wr) begin
      if (paddr == ADDR_CTRL) begin
        ctrl_q <= pwdata;
      end
      if (paddr == ADDR_MODE) begin
        mode_q <= pwdata[NODES-1:0];
      end
      if (paddr == ADDR_MASK) begin
        mask_q <= pwdata[1:0];
      end
    end
  end

  // Set wins over write-one-to-clear; the timer clear command only
  // touches the error bit
  always_ff @(posedge clk) begin
    if (srst) begin
      stat_q <= '0;
    end else begin
      stat_q[ST_ERR] <= err_set || (stat_q[ST_ERR] &&
        !(wt_clr || (wr && paddr == ADDR_STAT && pwdata[ST_ERR])));
      stat_q[ST_RCV] <= evt.rx_valid || (stat_q[ST_RCV] &&
        !(wr && paddr == ADDR_STAT && pwdata[ST_RCV]));
    end
  end

  assign rdata = (paddr == ADDR_CTRL) ? ctrl_q :
                 (paddr == ADDR_MODE) ? {1'b0, mode_q} :
                 (paddr == ADDR_FLAGS) ? {1'b0, evt.flags} :
                 (paddr == ADDR_STAT) ? {30'h0, stat_q} :
                 (paddr == ADDR_MASK) ? {30'h0, mask_q} : 32'h0;

  always_ff @(posedge clk) begin
    if (srst) begin
      prdata_q <= '0;
    end else if (psel && !penable && !pwrite) begin
      prdata_q <= rdata;
    end
  end
  assign prdata = rd ? prdata_q : 32'h0;

  assign irq = |(stat_q & mask_q);
endmodule // snwt_top

// *** pkg/snwt_pkg.sv ***
// Overview of operation
// - Carry code n picks watch counter bit n
// - Tick is 512 crystal clocks doubled per code up to code 3
// - Clear command zeroes remote-buffer page flags up to highest id
// - Packet from node sets that node's flag
// - Set monitored flag holds until next clear command or clean carry-out
// - Carry-out with any monitored flag clear sets error
// - Check only remote-buffer pages up to highest id
// - All monitored flags set: clear them at carry-out
// - Error flag is a maskable interrupt source
// - Timer clear command clears only error flag
// - Timer starts at soft reset release
package snwt_pkg;
  localparam int NODES = 31;
  localparam int ID_W = 5;
  localparam int CNT_W = 16;
  localparam int BASE_TICK = 512;
  localparam int PRE_W = 12;
  localparam logic [11:0] ADDR_CTRL = 12'h000;
  localparam logic [11:0] ADDR_MODE = 12'h004;
  localparam logic [11:0] ADDR_FLAGS = 12'h008;
  localparam logic [11:0] ADDR_CMD = 12'h00C;
  localparam logic [11:0] ADDR_STAT = 12'h010;
  localparam logic [11:0] ADDR_MASK = 12'h014;
  localparam int CTRL_RST = 0;
  localparam int CTRL_RES_LSB = 4;
  localparam int CTRL_CARRY_LSB = 8;
  localparam int CTRL_HIGHEST_NODE_ID_LSB = 16;
  localparam int CMD_FLAG_CLR = 0;
  localparam int CMD_WT_CLR = 1;
  localparam int ST_ERR = 0;
  localparam int ST_RCV = 1;
  localparam logic [31:0] CTRL_RESET = 32'h001F0101;
endpackage

// *** pkg/snwt_evt_if.sv ***
`timescale 1ns/1ps
interface snwt_evt_if;
  logic rx_valid;
  logic [4:0] rx_sid;
  logic flag_clr;
  logic [30:0] monitor;
  logic [30:0] flags;
  modport src (output rx_valid, rx_sid, flag_clr, monitor,
               input flags);
  modport dst (input rx_valid, rx_sid, flag_clr, monitor,
               output flags);
endinterface

// *** hdl/snwt_prescale.sv ***
`timescale 1ns/1ps
module snwt_prescale
  import snwt_pkg::*;
(
  // Clock and reset
  input wire logic clk,
  input wire logic srst,
  // Control
  input wire logic run,
  input wire logic [2:0] res_sel,
  // Tick enable
  output logic tick
);
  logic [PRE_W-1:0] cnt_q;
  logic [PRE_W-1:0] limit;
  // Unsupported codes with the top bit set fall back to code 0
  assign limit = res_sel[2] ? PRE_W'(BASE_TICK - 1)
               : PRE_W'((BASE_TICK << res_sel[1:0]) - 1);
  assign tick = run && (cnt_q == limit);
  always_ff @(posedge clk) begin
    if (srst || !run || tick) begin
      cnt_q <= '0;
    end else begin
      cnt_q <= cnt_q + 1'b1;
    end
  end
endmodule // snwt_prescale

// *** hdl/snwt_flags.sv ***
`timescale 1ns/1ps
module snwt_flags
  import snwt_pkg::*;
(
  // Clock and reset
  input wire logic clk,
  input wire logic srst,
  // Events
  snwt_evt_if.dst evt
);
  logic [NODES-1:0] flags_q;
  assign evt.flags = flags_q;
  genvar i;
  for (i = 0; i < NODES; i++) begin : g_flag
    always_ff @(posedge clk) begin
      if (srst) begin
        flags_q[i] <= 1'b0;
      end else if (evt.rx_valid && evt.rx_sid == ID_W'(i + 1)) begin
        // Reception wins over a clear in the same cycle
        flags_q[i] <= 1'b1;
      end else if (evt.flag_clr && evt.monitor[i]) begin
        flags_q[i] <= 1'b0;
      end
    end
  end
endmodule // snwt_flags

// *** test/snwt_top_assertions.sv ***
`timescale 1ns/1ps
module snwt_top_assertions
  import snwt_pkg::*;
(
  // Clock and reset
  input logic clk,
  input logic srst,
  // APB
  input logic psel,
  input logic penable,
  input logic pwrite,
  input logic [11:0] paddr,
  input logic [31:0] pwdata,
  input logic [31:0] prdata,
  input logic pready,
  input logic pslverr,
  // Interrupt
  input logic irq
);
  wire acc = psel && penable;
  default clocking @(posedge clk); endclocking
  default disable iff (srst);
  a_ready_now: assert property (acc |-> pready)
    else $error("late ready");
  a_idle_zero: assert property (!acc |-> prdata == 32'h0)
    else $error("data outside access");
  a_map_err: assert property (acc && paddr > ADDR_MASK |-> pslverr)
    else $error("hole not refused");
  a_map_ok: assert property (acc && paddr[1:0] == 2'h0 &&
    paddr <= ADDR_MASK |-> !pslverr) else $error("register refused");
  a_cmd_zero: assert property (acc && !pwrite && paddr == ADDR_CMD
    |-> prdata == 32'h0) else $error("command read back");
  a_hole_zero: assert property (acc && !pwrite && pslverr
    |-> prdata == 32'h0) else $error("hole read data");
  a_irq_reset: assert property ($past(srst) |-> !irq)
    else $error("irq after reset");
  a_mask_quiet: assert property (acc && pwrite &&
    paddr == ADDR_MASK && pwdata == 32'h0 |-> ##[1:2] !irq)
    else $error("irq while masked");
endmodule // snwt_top_assertions
bind snwt_top snwt_top_assertions u_chk(.clk(clk), .srst(srst),
  .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
  .pwdata(pwdata), .prdata(prdata), .pready(pready),
  .pslverr(pslverr), .irq(irq));

// *** test/snwt_rx_model.sv ***
`timescale 1ns/1ps
module snwt_rx_model (
  // Clock
  input logic clk,
  // Reception events
  output logic rx_done,
  output logic [4:0] rx_sid
);
  initial rx_done = 1'b0;
  initial rx_sid = 5'h1F;
  // Id flips when idle so a stale id cannot pass
  task automatic send(input logic [4:0] sid);
    @(posedge clk);
    rx_done <= 1'b1;
    rx_sid <= sid;
    @(posedge clk);
    rx_done <= 1'b0;
    rx_sid <= ~sid;
  endtask
endmodule // snwt_rx_model

// *** test/silent_node_warning_timer_bench.sv ***
`timescale 1ns/1ps
module silent_node_warning_timer_bench;
  import snwt_pkg::*;
  logic clk = 1'b0, srst = 1'b1, psel = 1'b0, penable = 1'b0;
  logic pwrite = 1'b0, pready, pslverr, rx_done, irq;
  logic [11:0] paddr = 12'h0;
  logic [31:0] pwdata = 32'h0, prdata, q;
  logic [4:0] rx_sid;
  int n_mismatch = 0, n_checks = 0, cyc = 0;
  always #10 clk = ~clk;
  snwt_rx_model RX(.clk(clk), .rx_done(rx_done), .rx_sid(rx_sid));
  snwt_top DUT(.clk(clk), .srst(srst), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .rx_done(rx_done),
    .rx_sid(rx_sid), .irq(irq));
  task automatic chk(input string nm, input logic [31:0] got, e);
    n_checks++;
    if (got !== e) begin
      n_mismatch++;
      $display("unexpected %s exp %h got %h", nm, e, got);
    end
  endtask
  task automatic bus(input logic w, input logic [11:0] a,
    input logic [31:0] d);
    @(posedge clk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    do @(posedge clk); while (pready !== 1'b1);
    q = prdata;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic rd(input logic [11:0] a, input logic [31:0] e);
    bus(1'b0, a, 32'h0);
    chk("reg", q, e);
  endtask
  task automatic wrap_up;
    $display("checks %0d mismatches %0d", n_checks, n_mismatch);
    if (n_mismatch == 0 && n_checks > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc == 9000) begin
      n_mismatch++;
      wrap_up;
    end
  end
  initial begin
    repeat (2) @(posedge clk);
    srst <= 1'b0;
    rd(ADDR_CTRL, CTRL_RESET);
    rd(12'h018, 32'h0);
    rd(ADDR_CMD, 32'h0);
    $display("reset test done");
    // Node 6 is remote but above the highest id, node 3 free format
    bus(1'b1, ADDR_MODE, 32'h3B);
    bus(1'b1, ADDR_CTRL, 32'h00050101);
    bus(1'b1, ADDR_CTRL, 32'h00050100);
    RX.send(5'h01);
    RX.send(5'h05);
    RX.send(5'h02);
    RX.send(5'h01);
    rd(ADDR_FLAGS, 32'h13);
    repeat (900) @(posedge clk);
    rd(ADDR_STAT, 32'h2);
    repeat (200) @(posedge clk);
    rd(ADDR_STAT, 32'h3);
    rd(ADDR_FLAGS, 32'h13);
    bus(1'b1, ADDR_CMD, 32'h2);
    rd(ADDR_STAT, 32'h2);
    rd(ADDR_FLAGS, 32'h13);
    bus(1'b1, ADDR_CMD, 32'h1);
    rd(ADDR_FLAGS, 32'h0);
    $display("silent test done");
    RX.send(5'h01);
    RX.send(5'h02);
    RX.send(5'h04);
    RX.send(5'h05);
    repeat (1024) @(posedge clk);
    rd(ADDR_FLAGS, 32'h0);
    rd(ADDR_STAT, 32'h2);
    repeat (1024) @(posedge clk);
    rd(ADDR_STAT, 32'h3);
    $display("period test done");
    bus(1'b1, ADDR_MASK, 32'h1);
    repeat (2) @(posedge clk);
    chk("irq", {31'h0, irq}, 32'h1);
    bus(1'b1, ADDR_STAT, 32'h1);
    repeat (2) @(posedge clk);
    chk("irq", {31'h0, irq}, 32'h0);
    bus(1'b1, ADDR_MASK, 32'h0);
    $display("irq test done");
    wrap_up;
  end
endmodule // silent_node_warning_timer_bench
